// ==== hdl/wdtu_top.sv ====
// Watchdog unit with its control register, status, mask and AXI4-Lite slave.
// Assumes one write and one read at most outstanding, as AXI4-Lite masters do.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// RULE1 - Counts from reset, longest timeout, reset mode.
// RULE2 - Configuration accepted only once between resets.
// RULE3 - Keys 3333h, CCCCh, then configuration word.
// RULE4 - Keys AAAAh, 5555h restart the count.
// RULE5 - Running count never readable.
// RULE6 - Longest timeout is 1.67 s at 40MHz.
// RULE7 - Configuration selects interrupt or reset on timeout.
// RULE8 - Interrupt timeout sets flag bit 12.
// RULE9 - Handler tests and clears the interrupt flag.
// RULE10 - Timeout with flag set resets instead.
// RULE11 - Watchdog reset sets flag bit 13.
// RULE12 - Any control read or write clears flag 13.
// RULE13 - Watchdog reset skips pin resampling, else normal.
// RULE14 - Broken key sequence discarded, restart from first.
module wdtu_top
    import wdtu_pkg::*;
#(
    parameter int P_TMAX_CYC = WDTU_TMAX_CYC
)
(
    // Clock and reset.
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Register bus.
    input  wire wdtu_axi_req_t i_axi,
    output wdtu_axi_rsp_t      o_axi,
    // System events.
    output logic               o_irq,
    output logic               o_nmi,
    output logic               o_sys_rst,
    output logic               o_skip_resample
);

    ////////////////////////////////////////////////////////////////////
    wdtu_state_t           st;
    wdtu_state_t           next_st;
    logic                  wr_go;
    logic                  rd_go;
    logic                  ctrl_wr;
    logic                  ctrl_rd;
    logic                  restart;
    logic                  tmo;
    logic [15:0]           wv;
    logic [WDTU_CNT_W-1:0] limit;

    function automatic logic [WDTU_CNT_W-1:0] tmo_limit(input logic [2:0] sel);
        tmo_limit = WDTU_CNT_W'(P_TMAX_CYC >> (WDTU_SEL_MAX - sel)); // RULE6
    endfunction : tmo_limit

    function automatic logic [31:0] strb_mask(input logic [31:0] d, input logic [3:0] s);
        strb_mask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        wv      = st.wdata[15:0];
        wr_go   = st.aw_have && st.w_have;
        rd_go   = st.ar_have && !wr_go;
        ctrl_wr = wr_go && (st.awaddr == WDTU_CTRL_OFS);
        ctrl_rd = rd_go && (st.araddr == WDTU_CTRL_OFS);
        restart = 1'b0;
        limit   = tmo_limit(st.sel);
        tmo     = (st.rstcnt == 3'h0) && (st.cnt >= limit - WDTU_CNT_W'(1));
        next_st.nmi = 1'b0;

        // Bus handshakes.
        if (st.axi.bvalid && i_axi.bready)
        begin
            next_st.axi.bvalid = 1'b0;
        end
        if (st.axi.rvalid && i_axi.rready)
        begin
            next_st.axi.rvalid = 1'b0;
        end
        if (i_axi.awvalid && st.axi.awready)
        begin
            next_st.aw_have = 1'b1;
            next_st.awaddr  = i_axi.awaddr;
        end
        if (i_axi.wvalid && st.axi.wready)
        begin
            next_st.w_have = 1'b1;
            next_st.wdata  = strb_mask(i_axi.wdata, i_axi.wstrb);
        end
        if (i_axi.arvalid && st.axi.arready)
        begin
            next_st.ar_have = 1'b1;
            next_st.araddr  = i_axi.araddr;
        end

        // Register writes.
        if (wr_go)
        begin
            next_st.aw_have    = 1'b0;
            next_st.w_have     = 1'b0;
            next_st.axi.bvalid = 1'b1;
            next_st.axi.bresp  = WDTU_RESP_OKAY;
            case (st.awaddr)
                WDTU_CTRL_OFS: ;
                WDTU_STAT_OFS: next_st.stat = st.stat & ~wv[1:0];
                WDTU_MASK_OFS: next_st.mask = wv[1:0];
                default:       next_st.axi.bresp = WDTU_RESP_SLV;
            endcase
        end

        // Register reads; the count is never placed on the bus.
        if (rd_go)
        begin
            next_st.ar_have    = 1'b0;
            next_st.axi.rvalid = 1'b1;
            next_st.axi.rresp  = WDTU_RESP_OKAY;
            next_st.axi.rdata  = 32'h0; // RULE5
            case (st.araddr)
                WDTU_CTRL_OFS:
                begin
                    next_st.axi.rdata[WDTU_MODE_BIT]          = st.mode;
                    next_st.axi.rdata[WDTU_RSTF_BIT]          = st.rstf;
                    next_st.axi.rdata[WDTU_NMIF_BIT]          = st.nmif;
                    next_st.axi.rdata[WDTU_SEL_LSB +: 3]      = st.sel;
                end
                WDTU_STAT_OFS: next_st.axi.rdata[1:0] = st.stat;
                WDTU_MASK_OFS: next_st.axi.rdata[1:0] = st.mask;
                default:       next_st.axi.rresp = WDTU_RESP_SLV;
            endcase
        end

        // Key sequences; any other control access breaks them.
        if (ctrl_wr)
        begin
            case (st.seq)
                SEQ_IDLE:
                begin
                    if (wv == WDTU_KEY_UNL1) // RULE3
                    begin
                        next_st.seq = SEQ_UNL1;
                    end
                    else if (wv == WDTU_KEY_RST1) // RULE4
                    begin
                        next_st.seq = SEQ_RST1;
                    end
                end
                SEQ_UNL1:
                begin
                    next_st.seq = (wv == WDTU_KEY_UNL2) ? SEQ_UNL2 : SEQ_IDLE; // RULE3 RULE14
                end
                SEQ_UNL2:
                begin
                    next_st.seq = SEQ_IDLE;
                    if (!st.locked) // RULE2
                    begin
                        next_st.locked = 1'b1;
                        next_st.mode   = wv[WDTU_MODE_BIT]; // RULE7
                        next_st.sel    = wv[WDTU_SEL_LSB +: 3];
                    end
                    if (!wv[WDTU_NMIF_BIT])
                    begin
                        next_st.nmif = 1'b0;
                    end
                end
                SEQ_RST1:
                begin
                    next_st.seq = SEQ_IDLE; // RULE14
                    restart     = (wv == WDTU_KEY_RST2); // RULE4
                end
                default: next_st.seq = SEQ_IDLE;
            endcase
        end
        else if (ctrl_rd)
        begin
            next_st.seq = SEQ_IDLE; // RULE14
        end
        if (ctrl_wr || ctrl_rd)
        begin
            next_st.rstf = 1'b0; // RULE12
        end

        // Counter and timeout; a timeout overrides any clear in the same cycle.
        next_st.cnt = restart ? '0 : st.cnt + WDTU_CNT_W'(1);
        if (st.rstcnt != 3'h0)
        begin
            next_st.rstcnt = st.rstcnt - 3'h1;
            next_st.cnt    = '0;
        end
        if (tmo)
        begin
            next_st.cnt = '0;
            if (st.mode && !st.nmif) // RULE7
            begin
                next_st.nmif              = 1'b1; // RULE8
                next_st.nmi               = 1'b1;
                next_st.stat[WDTU_EV_NMI] = 1'b1;
            end
            else
            begin
                // Own reset of the unit; status and mask survive it, and the reset flag is set.
                next_st.seq               = SEQ_IDLE; // RULE10
                next_st.locked            = 1'b0; // RULE13
                next_st.mode              = WDTU_MODE_RST;
                next_st.sel               = WDTU_SEL_RST;
                next_st.nmif              = 1'b0;
                next_st.rstf              = 1'b1; // RULE11
                next_st.rstcnt            = WDTU_RST_PULSE;
                next_st.stat[WDTU_EV_RST] = 1'b1;
            end
        end

        next_st.sysrst      = (next_st.rstcnt != 3'h0);
        next_st.irq         = |(next_st.stat & next_st.mask);
        next_st.axi.awready = !next_st.aw_have && !next_st.axi.bvalid;
        next_st.axi.wready  = !next_st.w_have && !next_st.axi.bvalid;
        next_st.axi.arready = !next_st.ar_have && !next_st.axi.rvalid;
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st             <= '0; // RULE1
            st.mode        <= WDTU_MODE_RST;
            st.sel         <= WDTU_SEL_RST;
            st.axi.awready <= 1'b1;
            st.axi.wready  <= 1'b1;
            st.axi.arready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_axi           = st.axi;
    assign o_irq           = st.irq;
    assign o_nmi           = st.nmi;
    assign o_sys_rst       = st.sysrst;
    assign o_skip_resample = st.sysrst;

    ////////////////////////////////////////////////////////////////////
    // Checks on the unit's own behaviour.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    reset_defaults_a: assert property ($fell(i_rst) |-> st.sel == WDTU_SEL_RST && !st.mode // RULE1
        && !st.locked && st.cnt == '0 ##1 st.cnt == WDTU_CNT_W'(1))
        else $error("Watchdog not counting in default mode after reset.");

    config_once_a: assert property ($past(st.locked) && st.locked // RULE2
        |-> $stable(st.mode) && $stable(st.sel))
        else $error("Configuration changed after it was locked.");

    unlock_write_a: assert property (st.seq == SEQ_UNL2 && ctrl_wr && !st.locked && !tmo // RULE3
        |=> st.locked && st.sel == $past(wv[2:0]))
        else $error("Configuration write after both keys was not taken.");

    restart_cnt_a: assert property (st.seq == SEQ_RST1 && ctrl_wr && wv == WDTU_KEY_RST2 // RULE4
        |=> st.cnt == '0 ##1 st.cnt == WDTU_CNT_W'(1))
        else $error("Restart keys did not restart the count.");

    count_hidden_a: assert property (st.axi.rvalid |-> st.axi.rdata[31:16] == 16'h0 // RULE5
        && st.axi.rdata[11:3] == 9'h0)
        else $error("Read data exposes more than the control fields.");

    longest_tmo_a: assert property (st.cnt < WDTU_CNT_W'(P_TMAX_CYC)) // RULE6
        else $error("Count ran past the longest timeout.");

    nmi_flag_a: assert property (tmo && st.mode && !st.nmif // RULE8
        |=> st.nmif && o_nmi && !o_sys_rst)
        else $error("Interrupt-mode timeout did not raise the flag and interrupt.");

    second_tmo_a: assert property (tmo && st.nmif |=> (o_sys_rst && !o_nmi) [*4]) // RULE10
        else $error("Repeat timeout did not reset the system.");

    reset_flag_a: assert property ($rose(o_sys_rst) |-> st.rstf && $past(tmo)) // RULE11
        else $error("Watchdog reset without its flag or its cause.");

    flag_clear_a: assert property ((ctrl_wr || ctrl_rd) && !tmo |=> !st.rstf) // RULE12
        else $error("Control access left the reset flag set.");

    skip_sample_a: assert property (o_sys_rst |-> o_skip_resample && st.cnt == '0) // RULE13
        else $error("Watchdog reset did not hold pin resampling off.");

    seq_break_a: assert property (st.seq == SEQ_UNL1 && ctrl_rd && !tmo // RULE14
        |=> st.seq == SEQ_IDLE)
        else $error("Broken key sequence was not discarded.");

endmodule : wdtu_top

// ==== common/wdtu_pkg.sv ====
// Constants, bus carriers and state layout of the watchdog unit.
// Assumes a 40 MHz processor clock and a 32-bit AXI4-Lite master.
package wdtu_pkg;
    ////////////////////////////////////////////////////////////////////
    localparam int          WDTU_ADDR_W     = 8;
    localparam logic [7:0]  WDTU_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  WDTU_STAT_OFS   = 8'h04;
    localparam logic [7:0]  WDTU_MASK_OFS   = 8'h08;
    localparam logic [15:0] WDTU_KEY_UNL1   = 16'h3333;
    localparam logic [15:0] WDTU_KEY_UNL2   = 16'hCCCC;
    localparam logic [15:0] WDTU_KEY_RST1   = 16'hAAAA;
    localparam logic [15:0] WDTU_KEY_RST2   = 16'h5555;
    localparam int          WDTU_MODE_BIT   = 15;
    localparam int          WDTU_RSTF_BIT   = 13;
    localparam int          WDTU_NMIF_BIT   = 12;
    localparam int          WDTU_SEL_LSB    = 0;
    localparam logic [2:0]  WDTU_SEL_RST    = 3'h7;
    localparam logic [2:0]  WDTU_SEL_MAX    = 3'h7;
    localparam logic        WDTU_MODE_RST   = 1'b0;
    localparam int          WDTU_EV_NMI     = 0;
    localparam int          WDTU_EV_RST     = 1;
    localparam logic [1:0]  WDTU_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  WDTU_RESP_SLV   = 2'h2;
    ////////////////////////////////////////////////////////////////////
    localparam int          WDTU_CLK_KHZ    = 40000;
    localparam int          WDTU_TMAX_MS    = 1670;
    localparam int          WDTU_TMAX_CYC   = WDTU_TMAX_MS * WDTU_CLK_KHZ;
    localparam int          WDTU_CNT_W      = 27;
    localparam logic [2:0]  WDTU_RST_PULSE  = 3'h4;
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_UNL1, SEQ_UNL2, SEQ_RST1} wdtu_seq_t;

    typedef struct packed {
        logic                   awvalid;
        logic [WDTU_ADDR_W-1:0] awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [WDTU_ADDR_W-1:0] araddr;
        logic                   rready;
    } wdtu_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wdtu_axi_rsp_t;

    typedef struct packed {
        logic [WDTU_CNT_W-1:0]  cnt;
        wdtu_seq_t              seq;
        logic                   locked;
        logic                   mode;
        logic [2:0]             sel;
        logic                   nmif;
        logic                   rstf;
        logic [1:0]             stat;
        logic [1:0]             mask;
        logic                   aw_have;
        logic                   w_have;
        logic [WDTU_ADDR_W-1:0] awaddr;
        logic [31:0]            wdata;
        logic                   ar_have;
        logic [WDTU_ADDR_W-1:0] araddr;
        wdtu_axi_rsp_t          axi;
        logic [2:0]             rstcnt;
        logic                   sysrst;
        logic                   nmi;
        logic                   irq;
    } wdtu_state_t;
endpackage : wdtu_pkg

// ==== sim/test_watchdog_timer_unit.sv ====
// Self-checking bench for the watchdog unit, driven through its AXI4-Lite register port.
// Assumes a short timeout parameter so that every timeout in the run fits in a few hundred cycles.
`timescale 1ns/1ps
module test_watchdog_timer_unit;
    import wdtu_pkg::*;
    localparam int         P_TMAX = 256;
    localparam logic [7:0] C      = WDTU_CTRL_OFS;
    localparam logic [7:0] S      = WDTU_STAT_OFS;
    localparam logic [7:0] M      = WDTU_MASK_OFS;
    localparam logic [1:0] OK     = WDTU_RESP_OKAY;
    localparam logic [1:0] SE     = WDTU_RESP_SLV;
    logic          i_clk     = 1'b0;
    logic          i_rst     = 1'b1;
    wdtu_axi_req_t axi       = '0;
    wdtu_axi_rsp_t o_axi;
    logic          o_irq;
    logic          o_nmi;
    logic          o_sys_rst;
    logic          o_skip;
    logic          prev      = 1'b0;
    logic [31:0]   rv;
    int            fails     = 0;
    int            n_checks  = 0;
    int            cyc       = 0;
    int            n_rst     = 0;
    int            first_rst = 0;
    int            n;
    int            w;
    ////////////////////////////////////////////////////////////////////////
    wdtu_top #(.P_TMAX_CYC(P_TMAX)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_axi(axi),
        .o_axi(o_axi), .o_irq(o_irq), .o_nmi(o_nmi), .o_sys_rst(o_sys_rst),
        .o_skip_resample(o_skip));

    always #12.5 i_clk = ~i_clk;

    // Rising edges of the reset request are counted so that missing restarts show up.
    always @(posedge i_clk)
    begin
        cyc  <= i_rst ? 0 : cyc + 1;
        prev <= o_sys_rst;
        if (o_sys_rst && !prev)
        begin
            n_rst <= n_rst + 1;
            if (n_rst == 0)
                first_rst <= cyc;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // A response code of 3 is never sent, so it marks a write that got no answer.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = OK);
        logic [1:0] r;
        r = 2'h3;
        @(posedge i_clk);
        axi.awvalid <= 1'b1;
        axi.awaddr  <= a;
        axi.wvalid  <= 1'b1;
        axi.wdata   <= {16'h0000, d};
        axi.wstrb   <= 4'hF;
        axi.bready  <= 1'b1;
        // Only the watchdog process ends a wait for an answer that never comes.
        while (r === 2'h3)
        begin
            @(posedge i_clk);
            if (axi.awvalid && o_axi.awready)
                axi.awvalid <= 1'b0;
            if (axi.wvalid && o_axi.wready)
                axi.wvalid <= 1'b0;
            if (o_axi.bvalid)
            begin
                axi.bready <= 1'b0;
                r = o_axi.bresp;
            end
        end
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = OK);
        logic [1:0] r;
        r = 2'h3;
        @(posedge i_clk);
        axi.arvalid <= 1'b1;
        axi.araddr  <= a;
        axi.rready  <= 1'b1;
        while (r === 2'h3)
        begin
            @(posedge i_clk);
            if (axi.arvalid && o_axi.arready)
                axi.arvalid <= 1'b0;
            if (o_axi.rvalid)
            begin
                axi.rready <= 1'b0;
                r = o_axi.rresp;
                rv = o_axi.rdata;
            end
        end
        chk({30'h0, r}, {30'h0, er});
        chk(rv, exp);
    endtask : rd

    task automatic wait_ev(input logic rst_ev, input int lim);
        for (n = 0; n < lim; n++)
        begin
            @(posedge i_clk);
            if (rst_ev ? o_sys_rst : o_nmi)
                break;
        end
        chk(n < lim, 1);
    endtask : wait_ev

    task kick;
        wr(C, WDTU_KEY_RST1);
        wr(C, WDTU_KEY_RST2);
    endtask : kick

    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fails++;
        results();
    end

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(C, 32'h0000_0007);
        rd(S, 32'h0);
        rd(M, 32'h0);
        rd(8'h0C, 32'h0, SE);
        wr(8'h0C, 16'h0001, SE);
        $display("test defaults done");
        // Nothing restarts the count here, so the reset-mode timeout must arrive on time.
        wait_ev(1'b1, 400);
        w = 1;
        for (int k = 0; k < 6; k++)
        begin
            @(posedge i_clk);
            w += o_sys_rst;
            chk(o_skip, o_sys_rst);
        end
        chk(w, 4);
        chk(first_rst >= P_TMAX - 2 && first_rst <= P_TMAX + 2, 1);
        rd(C, 32'h0000_2007);
        rd(C, 32'h0000_0007);
        rd(S, 32'h2);
        chk(o_irq, 0);
        wr(M, 16'h0003);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1);
        wr(S, 16'h0002);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 0);
        rd(S, 32'h0);
        $display("test reset mode done");
        kick();
        w = n_rst;
        repeat (5)
        begin
            repeat (200) @(posedge i_clk);
            kick();
        end
        chk(n_rst, w);
        wr(C, WDTU_KEY_RST1);
        rd(C, 32'h0000_0007);
        wr(C, WDTU_KEY_RST2);
        wait_ev(1'b1, 300);
        chk(n < 250, 1);
        rd(C, 32'h0000_2007);
        // The reset event of this test is cleared so that later status reads start clean.
        wr(S, 16'h0002);
        $display("test restart done");
        kick();
        wr(C, WDTU_KEY_UNL1);
        rd(C, 32'h0000_0007);
        wr(C, WDTU_KEY_UNL2);
        wr(C, 16'h8006);
        rd(C, 32'h0000_0007);
        wr(C, WDTU_KEY_UNL1);
        wr(C, 16'h1234);
        wr(C, WDTU_KEY_UNL2);
        wr(C, 16'h8006);
        rd(C, 32'h0000_0007);
        $display("test broken unlock done");
        wr(C, WDTU_KEY_UNL1);
        wr(C, WDTU_KEY_UNL2);
        wr(C, 16'h8006);
        kick();
        rd(C, 32'h0000_8006);
        wr(C, WDTU_KEY_UNL1);
        wr(C, WDTU_KEY_UNL2);
        wr(C, 16'h0002);
        rd(C, 32'h0000_8006);
        wait_ev(1'b0, 200);
        rd(C, 32'h0000_9006);
        rd(S, 32'h1);
        chk(o_irq, 1);
        wr(C, WDTU_KEY_UNL1);
        wr(C, WDTU_KEY_UNL2);
        wr(C, 16'h8006);
        rd(C, 32'h0000_8006);
        wait_ev(1'b0, 200);
        rd(C, 32'h0000_9006);
        wait_ev(1'b1, 200);
        rd(C, 32'h0000_2007);
        rd(S, 32'h3);
        wr(S, 16'h0003);
        rd(S, 32'h0);
        $display("test interrupt mode done");
        results();
    end
endmodule : test_watchdog_timer_unit
